/* design/lppg_pkg.sv */
// package for the low-power peripheral gating controller
// assumes one system clock domain; debug halt arrives from another clock
//
// Contract
// R01: stop instruction applies selected mode's run states
// R02: cpu and sram halted in all modes; code halts them only in wait, doze and stop, and runs them in run mode
// R03: general modules run in wait/doze, halt in stop
// R04: some modules follow their programmable run bits
// R05: always-on modules keep running in all modes
// R06: dedicated disable bit overrides automatic run state
// R07: wake-capable interrupt returns cpu to run
// R08: module resets end any low-power mode; code takes only M_RSTC resets in stop, M_SIM, M_RSTC, M_WDOG in wait/doze
// R09: stop mode accepts only listed wake sources
// R10: debug halt exits, then previous mode re-entered; code re-enters the mode selected when halt releases
// R11: debug port runs from its own clock
// R12: boundary-scan cannot wake the cpu
// R13: registered gates release on detection cycle
package lppg_pkg;
  // low_power_mode_select encodings
  localparam logic [1:0] LPPG_MODE_RUN = 2'h0;
  localparam logic [1:0] LPPG_MODE_DOZE = 2'h1;
  localparam logic [1:0] LPPG_MODE_WAIT = 2'h2;
  localparam logic [1:0] LPPG_MODE_STOP = 2'h3;
  // module index in the gate vector
  localparam int LPPG_NUM_MOD = 24;
  localparam int M_CPU = 0;
  localparam int M_SRAM = 1;
  localparam int M_SIM = 2;
  localparam int M_SDRAM = 3;
  localparam int M_CSEL = 4;
  localparam int M_DMA = 5;
  localparam int M_UART = 6;
  localparam int M_I2C = 7;
  localparam int M_QSPI = 8;
  localparam int M_DTIM = 9;
  localparam int M_INTC = 10;
  localparam int M_GPIO = 11;
  localparam int M_RSTC = 12;
  localparam int M_CCM = 13;
  localparam int M_PMM = 14;
  localparam int M_CLK = 15;
  localparam int M_EPORT = 16;
  localparam int M_WDOG = 17;
  localparam int M_PIT = 18;
  localparam int M_QCONV = 19;
  localparam int M_GPT = 20;
  localparam int M_CAN = 21;
  localparam int M_DBG = 22;
  localparam int M_SCAN = 23;
  // run masks per mode, bit set means module runs
  localparam logic [23:0] LPPG_RUN_WAIT = 24'hFFFFFC;
  localparam logic [23:0] LPPG_RUN_DOZE = 24'hFFFFFC;
  localparam logic [23:0] LPPG_RUN_STOP = 24'hC01C00;
  // modules whose state comes from programmable bits per mode
  localparam logic [23:0] LPPG_PROG_WAIT = 24'h020000;
  localparam logic [23:0] LPPG_PROG_DOZE = 24'h0E0000;
  localparam logic [23:0] LPPG_PROG_STOP = 24'h008000;
  // wake sources accepted per mode
  localparam logic [23:0] LPPG_WAKE_WAIT = 24'h7FF7E4;
  localparam logic [23:0] LPPG_WAKE_DOZE = 24'h7FF7E4;
  localparam logic [23:0] LPPG_WAKE_STOP = 24'h419400;
  localparam logic [23:0] LPPG_RST_WAIT = 24'h021004;
  localparam logic [23:0] LPPG_RST_STOP = 24'h001000;
  localparam logic [23:0] LPPG_ALL_ON = 24'hFFFFFF;

  typedef enum logic [1:0] {
    LPPG_ST_RUN = 2'b00,
    LPPG_ST_LOW = 2'b01,
    LPPG_ST_HALT = 2'b11
  } lppg_state_t;
endpackage : lppg_pkg

/* design/lppg_ctrl.sv */
// low-power gating controller: per-module run gates and wakeup
// assumes stop strobe, irq and reset requests are system-clock logic
`timescale 1ns/1ps
module lppg_ctrl
  import lppg_pkg::*;
#(
  parameter int NUM_MOD = LPPG_NUM_MOD
)
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic STOP_EXEC_IN,
  input wire logic [1:0] MODE_SEL_IN,
  input wire logic [NUM_MOD-1:0] PROG_RUN_IN,
  input wire logic [NUM_MOD-1:0] MOD_DISABLE_IN,
  input wire logic [NUM_MOD-1:0] MOD_IRQ_IN,
  input wire logic [NUM_MOD-1:0] MOD_RST_IN,
  input wire logic DBG_HALT_IN,
  output logic [NUM_MOD-1:0] MOD_RUN_OUT,
  output logic CPU_RUN_OUT,
  output logic WAKE_IRQ_OUT,
  output logic [1:0] ACTIVE_MODE_OUT,
  output logic LOW_POWER_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_MOD-1:0] run_mask(input logic [1:0] m,
    input logic [NUM_MOD-1:0] prog);
    logic [NUM_MOD-1:0] base;
    logic [NUM_MOD-1:0] pm;
    base = LPPG_ALL_ON;
    pm = '0;
    case (m)
      LPPG_MODE_WAIT:
      begin
        base = LPPG_RUN_WAIT;
        pm = LPPG_PROG_WAIT;
      end
      LPPG_MODE_DOZE:
      begin
        base = LPPG_RUN_DOZE;
        pm = LPPG_PROG_DOZE;
      end
      LPPG_MODE_STOP:
      begin
        base = LPPG_RUN_STOP;
        pm = LPPG_PROG_STOP;
      end
      default:
      begin
        base = LPPG_ALL_ON;
        pm = '0;
      end
    endcase
    return (base & ~pm) | (pm & prog); // [R03] [R04] [R05]
  endfunction : run_mask

  function automatic logic [NUM_MOD-1:0] wake_mask(input logic [1:0] m);
    case (m)
      LPPG_MODE_STOP: return LPPG_WAKE_STOP; // [R09]
      LPPG_MODE_WAIT: return LPPG_WAKE_WAIT;
      default: return LPPG_WAKE_DOZE;
    endcase
  endfunction : wake_mask

  function automatic logic [NUM_MOD-1:0] rst_mask(input logic [1:0] m);
    if (m == LPPG_MODE_STOP)
      return LPPG_RST_STOP;
    return LPPG_RST_WAIT;
  endfunction : rst_mask

  // ----------------------------------------------------------------
  // debug halt synchroniser (debug port on its own clock)
  // ----------------------------------------------------------------
  logic dbg_meta;
  logic dbg_sync;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
    begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      dbg_meta <= DBG_HALT_IN; // [R11]
      dbg_sync <= dbg_meta;
    end

  // ----------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------
  lppg_state_t state;
  lppg_state_t next_state;
  logic [1:0] mode;
  logic wake_irq;
  logic wake_rst;
  logic wake_any;
  logic [NUM_MOD-1:0] scan_clr;

  // boundary-scan never counts as a wake source
  assign scan_clr = ~(NUM_MOD'(1) << M_SCAN); // [R12]
  assign wake_irq = |(MOD_IRQ_IN & wake_mask(mode) & scan_clr); // [R07]
  assign wake_rst = |(MOD_RST_IN & rst_mask(mode) & scan_clr); // [R08]
  assign wake_any = wake_irq | wake_rst | dbg_sync; // [R10]

  always_comb
  begin
    next_state = state;
    case (state)
      LPPG_ST_RUN:
        if (dbg_sync)
          next_state = LPPG_ST_HALT;
        else if (STOP_EXEC_IN && MODE_SEL_IN != LPPG_MODE_RUN)
          next_state = LPPG_ST_LOW; // [R01]
      LPPG_ST_LOW:
        if (dbg_sync)
          next_state = LPPG_ST_HALT; // [R10]
        else if (wake_irq || wake_rst)
          next_state = LPPG_ST_RUN; // [R07] [R08]
      LPPG_ST_HALT:
        if (!dbg_sync)
          next_state = (mode != LPPG_MODE_RUN) ? LPPG_ST_LOW : LPPG_ST_RUN;
      default: next_state = LPPG_ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      state <= LPPG_ST_RUN;
    else if (CLK_EN_IN)
      state <= next_state;

  // remembered mode; updates during halt stay in effect
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      mode <= LPPG_MODE_RUN;
    else if (CLK_EN_IN)
    begin
      if (state == LPPG_ST_RUN && STOP_EXEC_IN)
        mode <= MODE_SEL_IN; // [R01]
      else if (state == LPPG_ST_HALT)
        mode <= MODE_SEL_IN; // [R10]
      else if (state == LPPG_ST_LOW && !dbg_sync && (wake_irq || wake_rst))
        mode <= LPPG_MODE_RUN;
    end

  // ----------------------------------------------------------------
  // gate outputs
  // ----------------------------------------------------------------
  logic [NUM_MOD-1:0] next_run;

  always_comb
  begin
    if (next_state == LPPG_ST_LOW && !wake_any)
      next_run = run_mask(next_state == state ? mode : MODE_SEL_IN,
        PROG_RUN_IN); // [R01] [R02]
    else
      next_run = LPPG_ALL_ON; // [R13]
    next_run = next_run & ~MOD_DISABLE_IN; // [R06]
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      MOD_RUN_OUT <= LPPG_ALL_ON;
    else if (CLK_EN_IN)
      MOD_RUN_OUT <= next_run; // [R13]

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      WAKE_IRQ_OUT <= 1'b0;
    else if (CLK_EN_IN)
      WAKE_IRQ_OUT <= (state == LPPG_ST_LOW) && wake_irq && !dbg_sync;

  assign CPU_RUN_OUT = (state != LPPG_ST_LOW); // [R02]
  assign ACTIVE_MODE_OUT = mode;
  assign LOW_POWER_OUT = (state == LPPG_ST_LOW);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  AST_ENTER: assert property (CLK_EN_IN && state == LPPG_ST_RUN && !dbg_sync
    && STOP_EXEC_IN && MODE_SEL_IN != LPPG_MODE_RUN |=> LOW_POWER_OUT) // [R01]
    else $error("stop did not enter low power");
  AST_CPU_OFF: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) |->
    !MOD_RUN_OUT[M_CPU] && !MOD_RUN_OUT[M_SRAM]) // [R02]
    else $error("cpu or sram running in low power");
  AST_STOP_GATE: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT)
    && mode == LPPG_MODE_STOP |-> !MOD_RUN_OUT[M_UART]
    && !MOD_RUN_OUT[M_DMA]) // [R03]
    else $error("module running in stop");
  AST_ALWAYS_ON: assert property (!MOD_DISABLE_IN[M_INTC] && $past(CLK_EN_IN)
    && !$past(MOD_DISABLE_IN[M_INTC]) |-> MOD_RUN_OUT[M_INTC]) // [R05]
    else $error("interrupt controller gated");
  AST_DISABLE: assert property (CLK_EN_IN && MOD_DISABLE_IN[M_GPIO]
    |=> !MOD_RUN_OUT[M_GPIO]) // [R06]
    else $error("disable not honoured");
  AST_WAKE: assert property (CLK_EN_IN && LOW_POWER_OUT && !dbg_sync
    && MOD_IRQ_IN[M_INTC] |=> CPU_RUN_OUT && WAKE_IRQ_OUT) // [R07] [R09]
    else $error("interrupt did not wake");
  AST_RESET_WAKE: assert property (CLK_EN_IN && LOW_POWER_OUT
    && MOD_RST_IN[M_RSTC] |=> CPU_RUN_OUT) // [R08]
    else $error("reset did not wake");
  AST_STOP_NOWAKE: assert property (CLK_EN_IN && LOW_POWER_OUT
    && mode == LPPG_MODE_STOP && !dbg_sync && MOD_RST_IN == '0
    && (MOD_IRQ_IN & LPPG_WAKE_STOP) == '0 |=> LOW_POWER_OUT) // [R09]
    else $error("wrong source woke stop");
  AST_HALT_BACK: assert property (CLK_EN_IN && state == LPPG_ST_HALT
    && !dbg_sync && mode != LPPG_MODE_RUN |=> LOW_POWER_OUT) // [R10]
    else $error("low power not re-entered");
  AST_SCAN: assert property (CLK_EN_IN && LOW_POWER_OUT && !dbg_sync
    && MOD_IRQ_IN == (NUM_MOD'(1) << M_SCAN) && MOD_RST_IN == '0
    |=> LOW_POWER_OUT) // [R12]
    else $error("scan woke cpu");
  AST_RELEASE: assert property (CLK_EN_IN && LOW_POWER_OUT && wake_any
    && MOD_DISABLE_IN == '0 |=> MOD_RUN_OUT == LPPG_ALL_ON) // [R13]
    else $error("gates not released");

  // ----------------------------------------------------------------
  // gate pattern checks
  // ----------------------------------------------------------------
  AST_WAIT_RUN: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R03]
    && mode == LPPG_MODE_WAIT && !$past(MOD_DISABLE_IN[M_UART])
    |-> MOD_RUN_OUT[M_UART]) else $error("uart gated in wait");
  AST_DOZE_RUN: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R03]
    && mode == LPPG_MODE_DOZE && !$past(MOD_DISABLE_IN[M_CAN])
    |-> MOD_RUN_OUT[M_CAN]) else $error("can gated in doze");
  AST_STOP_SIM: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R03]
    && mode == LPPG_MODE_STOP |-> !MOD_RUN_OUT[M_SIM]
    && !MOD_RUN_OUT[M_SDRAM]) else $error("sim or sdram running in stop");
  AST_STOP_CLKMOD: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R04]
    && mode == LPPG_MODE_STOP && !$past(MOD_DISABLE_IN[M_CLK])
    |-> MOD_RUN_OUT[M_CLK] == $past(PROG_RUN_IN[M_CLK]))
    else $error("clock module ignores its run bit");
  AST_DOZE_PROG: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R04]
    && mode == LPPG_MODE_DOZE && !$past(MOD_DISABLE_IN[M_PIT])
    |-> MOD_RUN_OUT[M_PIT] == $past(PROG_RUN_IN[M_PIT]))
    else $error("timer ignores its run bit");
  AST_WAIT_WDOG: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R04]
    && mode == LPPG_MODE_WAIT && !$past(MOD_DISABLE_IN[M_WDOG])
    |-> MOD_RUN_OUT[M_WDOG] == $past(PROG_RUN_IN[M_WDOG]))
    else $error("watchdog ignores its run bit");
  AST_RSTC_ON: assert property (!MOD_DISABLE_IN[M_RSTC] // [R05]
    && $past(CLK_EN_IN) && !$past(MOD_DISABLE_IN[M_RSTC])
    |-> MOD_RUN_OUT[M_RSTC]) else $error("reset controller gated");
  AST_DBG_ON: assert property (!MOD_DISABLE_IN[M_DBG] // [R05]
    && $past(CLK_EN_IN) && !$past(MOD_DISABLE_IN[M_DBG])
    |-> MOD_RUN_OUT[M_DBG]) else $error("debug port gated");
  AST_CPU_HELD: assert property (CLK_EN_IN && LOW_POWER_OUT // [R02]
    && !wake_any |=> !MOD_RUN_OUT[M_CPU] && !MOD_RUN_OUT[M_SRAM])
    else $error("cpu released without wake");

  // ----------------------------------------------------------------
  // entry and wake checks
  // ----------------------------------------------------------------
  AST_RUN_STAY: assert property (CLK_EN_IN && state == LPPG_ST_RUN // [R01]
    && !dbg_sync && !STOP_EXEC_IN |=> !LOW_POWER_OUT)
    else $error("low power without stop");
  AST_RUN_MODE0: assert property (CLK_EN_IN && state == LPPG_ST_RUN // [R01]
    && !dbg_sync && STOP_EXEC_IN && MODE_SEL_IN == LPPG_MODE_RUN
    |=> !LOW_POWER_OUT) else $error("run mode select entered low power");
  AST_EPORT_OFF: assert property (CLK_EN_IN && $rose(LOW_POWER_OUT) // [R09]
    && mode == LPPG_MODE_STOP |-> !MOD_RUN_OUT[M_EPORT])
    else $error("edge port running in stop");
  AST_EPORT_WAKE: assert property (CLK_EN_IN && LOW_POWER_OUT // [R09]
    && mode == LPPG_MODE_STOP && !dbg_sync && MOD_IRQ_IN[M_EPORT]
    |=> CPU_RUN_OUT) else $error("edge port did not wake stop");
  AST_WDOG_WAKE: assert property (CLK_EN_IN && LOW_POWER_OUT // [R08]
    && mode == LPPG_MODE_WAIT && MOD_RST_IN[M_WDOG] |=> CPU_RUN_OUT)
    else $error("watchdog reset did not wake");
  AST_SCAN_RST: assert property (CLK_EN_IN && LOW_POWER_OUT // [R12]
    && !dbg_sync && MOD_IRQ_IN == '0
    && MOD_RST_IN == (NUM_MOD'(1) << M_SCAN) |=> LOW_POWER_OUT)
    else $error("scan reset woke cpu");
  AST_WAKE_PULSE: assert property (CLK_EN_IN && WAKE_IRQ_OUT // [R07]
    |=> !WAKE_IRQ_OUT) else $error("wake pulse too long");
  AST_WAKE_MODE: assert property (CLK_EN_IN && WAKE_IRQ_OUT // [R07]
    |-> ACTIVE_MODE_OUT == LPPG_MODE_RUN) else $error("mode kept on wake");

  // ----------------------------------------------------------------
  // debug and enable checks
  // ----------------------------------------------------------------
  AST_DBG_EXIT: assert property (CLK_EN_IN && LOW_POWER_OUT // [R10]
    && dbg_sync |=> !LOW_POWER_OUT) else $error("halt did not exit");
  AST_HALT_MODE: assert property (CLK_EN_IN && state == LPPG_ST_HALT // [R10]
    |=> ACTIVE_MODE_OUT == $past(MODE_SEL_IN))
    else $error("halt mode change lost");
  AST_FREEZE: assert property (!CLK_EN_IN |=> $stable(MOD_RUN_OUT) // [R13]
    && $stable(LOW_POWER_OUT)) else $error("state moved while frozen");

  COV_STOP: cover property (LOW_POWER_OUT && mode == LPPG_MODE_STOP);
  COV_WAKE: cover property (WAKE_IRQ_OUT);
  COV_HALT: cover property (state == LPPG_ST_HALT ##1 LOW_POWER_OUT);
  COV_DOZE: cover property (LOW_POWER_OUT && mode == LPPG_MODE_DOZE);
  COV_RST_WAKE: cover property (LOW_POWER_OUT && wake_rst);
endmodule : lppg_ctrl

/* sim/lppg_periph_model.sv */
// peripheral interrupt sources facing the gating controller
// assumes fire and clear strobes from the bench on the system clock
`timescale 1ns/1ps
module lppg_periph_model
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic fire_in,
  input wire logic clr_in,
  input wire logic [4:0] idx_in,
  output logic [23:0] irq_out
);
  // ----------------------------------------
  // level request held until serviced
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_out <= 24'h000000;
    else if (clr_in)
      irq_out <= 24'h000000;
    else if (fire_in)
      irq_out[idx_in] <= 1'b1;
  end
endmodule : lppg_periph_model

/* sim/tb_lppg_ctrl.sv */
// self-checking bench for the low-power gating controller
// assumes the peripheral model drives the interrupt requests
`timescale 1ns/1ps
module tb_lppg_ctrl;
  import lppg_pkg::*;
  logic clk = 0, rst_n = 0, stp = 0, fire = 0, clr = 0, halt = 0, ce = 1;
  logic [1:0] mode = 2'h0;
  logic [4:0] idx = 5'h00;
  logic [23:0] prog = 24'h0A8000, dis = 24'h000000, rst = 24'h000000;
  logic [23:0] irq, run;
  logic cpu, wk, lp;
  logic [1:0] am;
  int fails = 0, check_count = 0;
  always #10 clk = ~clk;
  lppg_periph_model lppg_periph_model_inst (.clk_in(clk),
    .rst_n_in(rst_n), .fire_in(fire), .clr_in(clr), .idx_in(idx),
    .irq_out(irq));
  lppg_ctrl lppg_ctrl_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
    .CLK_EN_IN(ce), .STOP_EXEC_IN(stp), .MODE_SEL_IN(mode),
    .PROG_RUN_IN(prog), .MOD_DISABLE_IN(dis), .MOD_IRQ_IN(irq),
    .MOD_RST_IN(rst), .DBG_HALT_IN(halt), .MOD_RUN_OUT(run),
    .CPU_RUN_OUT(cpu), .WAKE_IRQ_OUT(wk), .ACTIVE_MODE_OUT(am),
    .LOW_POWER_OUT(lp));
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ----------------------------------------
  // expected gates and helpers
  // ----------------------------------------
  function automatic logic [23:0] mask(input logic [1:0] m);
    logic [23:0] r, p;
    r = (m == 2'h3) ? 24'hC01C00 : 24'hFFFFFC;
    p = (m == 2'h3) ? 24'h008000 : (m == 2'h1) ? 24'h0E0000 : 24'h020000;
    if (m == 2'h0)
      return ~dis;
    return ((r & ~p) | (prog & p)) & ~dis;
  endfunction : mask
  task automatic wait_lp(input logic v, output int n);
    n = 0;
    while (lp !== v)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8)
      begin
        fails++;
        wrap_up();
      end
    end
  endtask : wait_lp
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic enter(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    #1;
    chk("low_power", lp, m != 2'h0);
    chk("cpu_run", cpu, m == 2'h0);
    chk("mod_run", run, mask(m));
    chk("act_mode", am, m);
  endtask : enter
  task automatic try_wake(input bit is_rst, input int i, input logic ok);
    @(posedge clk);
    fire <= !is_rst;
    idx <= i[4:0];
    @(posedge clk);
    fire <= 1'b0;
    rst[i] <= is_rst;
    @(posedge clk);
    #1;
    chk("wake", lp, !ok);
    if (ok)
    begin
      chk("release", run, ~dis);
      chk("wake_irq", wk, !is_rst);
    end
    @(posedge clk);
    clr <= 1'b1;
    rst <= 24'h000000;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    chk("wake_end", wk, 24'h000000);
  endtask : try_wake
  task automatic freeze();
    @(posedge clk);
    ce <= 1'b0;
    mode <= LPPG_MODE_STOP;
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk("frozen", lp, 1'b0);
    chk("frozen_run", run, ~dis);
  endtask : freeze
  task automatic dbg_halt();
    int n;
    enter(LPPG_MODE_WAIT);
    @(posedge clk);
    halt <= 1'b1;
    wait_lp(1'b0, n);
    chk("halt_lat", n, 24'h000003);
    chk("halt_rel", run, ~dis);
    @(posedge clk);
    mode <= LPPG_MODE_STOP;
    @(posedge clk);
    halt <= 1'b0;
    wait_lp(1'b1, n);
    chk("reenter", am, LPPG_MODE_STOP);
    chk("re_gates", run, mask(LPPG_MODE_STOP));
    try_wake(0, 10, 1'b1);
  endtask : dbg_halt
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    enter(LPPG_MODE_RUN);
    freeze();
    for (int m = 1; m < 4; m++)
    begin
      enter(m[1:0]);
      try_wake(0, 23, 1'b0);
      try_wake(0, 6, m != 3);
      if (m == 3)
        try_wake(0, 16, 1'b1);
    end
    enter(LPPG_MODE_WAIT);
    try_wake(1, 21, 1'b0);
    try_wake(1, 17, 1'b1);
    enter(LPPG_MODE_STOP);
    try_wake(1, 17, 1'b0);
    try_wake(1, 12, 1'b1);
    @(posedge clk);
    dis <= 24'h400400;
    enter(LPPG_MODE_STOP);
    try_wake(1, 12, 1'b1);
    @(posedge clk);
    dis <= 24'h000000;
    dbg_halt();
    wrap_up();
  end
endmodule : tb_lppg_ctrl
